/* File: hw/psa_status_alarm.sv */
// psa_status_alarm: status and alarm bytes, maintenance commands, LED and
// latch-off policy of the rectifier management controller.
// assumes commands arrive already framed and pec-checked, one pulse per command,
// and that monitor inputs are on mclk; only the enable pin is asynchronous.
// Function
// - keep four status/alarm bytes, all returned together in one read.
// - every error or alarm flag reads 0 normal, 1 alarm.
// - pec mismatch sets command status bit 7, command dropped; clear resets.
// - command status bit 6 is 1 when set to restart after shutdown.
// - unsupported command sets bit 5 and asserts alert; clear resets it.
// - command status bit 4 is 1 at high-line power capacity.
// - failed isolation test sets bit 3 only, never the internal fault.
// - successful restart that clears the bytes sets command status bit 2.
// - bit 1 stays while data out of range; clear cannot reset it then.
// - bit 0 mirrors the enable pin, 1 means high and unit off.
// - unit status byte holds iso pass, faults, shutdown, LEDs, output on.
// - hardware alarm byte holds fan, primary, thermal, aux and delivery faults.
// - power delivery fault when own current differs from share by over 10A.
// - operating alarm byte holds limit, input, temperature, current, voltage flags.
// - overcurrent shutdown flag when output voltage falls below 39V in current limit.
// - lamp test cycles four LEDs 7 s on, 2 s off until stopped.
// - flash command flashes the ok-to-remove LED 0.5 s on, 0.5 s off.
// - dark command stops flashing and turns the ok-to-remove LED off.
// - unlock command permits protected EEPROM writes after about 10 ms.
// - lock command removes write permission from the protected EEPROM region.
// - in limit blink above 36V, hiccup below in restart mode, latched LED off.
// - latch policy command keeps unit latched off after ov, ot, oc shutdowns.
// - status read returns the four bytes with voltage, current, temperature.
// - clear resets iso pass, iso fail, restarted ok, bad cmd, bad data, pec.
// - successful restart clears old alarms from both alarm bytes and sets restarted-ok.
`include "psa_cfg.svh"
`default_nettype none

module psa_status_alarm #(
	parameter int MS_TICK_CYC = `PSA_MS_TICK_CYC
) (
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	input  wire logic        cmd_valid,
	input  wire logic [7:0]  cmd_code,
	input  wire logic        cmd_pec_ok,
	input  wire logic        data_out_of_range,
	input  wire logic        enable_pin,
	input  wire logic        high_line,
	input  wire logic        iso_done,
	input  wire logic        iso_pass,
	input  wire logic        restart_ok,
	input  wire logic        int_fault,
	input  wire logic        ext_fault,
	input  wire logic        shutdown,
	input  wire logic        output_on,
	input  wire logic        fan_fault,
	input  wire logic        no_primary,
	input  wire logic        primary_ot,
	input  wire logic        dcdc_ot,
	input  wire logic        out_below_bus,
	input  wire logic        tsense_fail,
	input  wire logic        aux5_fault,
	input  wire logic        power_limit,
	input  wire logic        current_limit,
	input  wire logic        primary_fail,
	input  wire logic        ot_shutdown,
	input  wire logic        ot_warning,
	input  wire logic        ov_shutdown,
	input  wire logic        vout_out_lim,
	input  wire logic        vin_out_lim,
	input  wire logic [15:0] vout_code,
	input  wire logic [15:0] iout_own,
	input  wire logic [15:0] iout_share,
	input  wire logic [7:0]  temp_code,
	output logic [7:0]       cmd_status,
	output logic [7:0]       unit_status,
	output logic [7:0]       hw_alarm,
	output logic [7:0]       op_alarm,
	output logic             rd_done,
	output logic [7:0]       rd_cmd_status,
	output logic [7:0]       rd_unit_status,
	output logic [7:0]       rd_hw_alarm,
	output logic [7:0]       rd_op_alarm,
	output logic [15:0]      rd_vout,
	output logic [7:0]       rd_iout,
	output logic [7:0]       rd_temp,
	output logic             alert_out,
	output logic             alert_oe,
	output logic [3:0]       front_led,
	output logic             eeprom_wr_ok,
	output logic             latched_off,
	output logic             hiccup
);

	// ----------------------------------------
	// command decode
	// ----------------------------------------
	logic cmd_known;
	logic pec_bad;
	logic bad_cmd;
	logic exec;
	logic do_clear;

	always_comb
	begin
		unique case (cmd_code)
			`PSA_CMD_OPERATION, `PSA_CMD_CLEAR, `PSA_CMD_VOUT_SET, `PSA_CMD_OV_LIMIT,
			`PSA_CMD_READ_STATUS, `PSA_CMD_LAMP_START, `PSA_CMD_LAMP_STOP,
			`PSA_CMD_OTR_FLASH, `PSA_CMD_OTR_DARK, `PSA_CMD_WR_UNLOCK,
			`PSA_CMD_WR_LOCK, `PSA_CMD_LATCH_POLICY, `PSA_CMD_AUTO_RESTART,
			`PSA_CMD_ISO_TEST, `PSA_CMD_RD_INPUT, `PSA_CMD_RD_FW, `PSA_CMD_RD_TIMER,
			`PSA_CMD_FAN_SET, `PSA_CMD_FAN_NORMAL, `PSA_CMD_RD_FAN, `PSA_CMD_STRETCH:
				cmd_known = 1'b1;
			default:
				cmd_known = 1'b0;
		endcase
	end

	assign pec_bad = cmd_valid & ~cmd_pec_ok;
	assign bad_cmd = cmd_valid & cmd_pec_ok & ~cmd_known;
	assign exec = cmd_valid & cmd_pec_ok & cmd_known;
	assign do_clear = exec && (cmd_code == `PSA_CMD_CLEAR);

	// ----------------------------------------
	// enable pin synchroniser
	// ----------------------------------------
	logic en_s1_ff;
	logic en_s2_ff;
	logic en_s3_ff;
	logic en_hi_ff;

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			en_s1_ff <= 1'b0;
			en_s2_ff <= 1'b0;
			en_s3_ff <= 1'b0;
			en_hi_ff <= 1'b0;
		end
		else
		begin
			en_s1_ff <= enable_pin;
			en_s2_ff <= en_s1_ff;
			en_s3_ff <= en_s2_ff;
			// take the level once two stages agree
			if (en_s2_ff == en_s3_ff)
				en_hi_ff <= en_s3_ff;
		end
	end

	// ----------------------------------------
	// restart policy and latch-off
	// ----------------------------------------
	logic latch_pol_ff;
	logic oc_trip;
	logic blink_zone;

	// overcurrent trips once output sags below 39V in current limit
	assign oc_trip = current_limit && (vout_code < `PSA_VOUT_OC_TRIP);
	assign blink_zone = (power_limit | current_limit) && (vout_code > `PSA_VOUT_BLINK_MIN);

	// one command sets the policy, kept until auto-restart or bias loss
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			latch_pol_ff <= 1'b0;
		else if (exec && cmd_code == `PSA_CMD_LATCH_POLICY)
			latch_pol_ff <= 1'b1;
		else if (exec && cmd_code == `PSA_CMD_AUTO_RESTART)
			latch_pol_ff <= 1'b0;
	end

	// latch on ov, ot or oc shutdown; only a restart releases it
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			latched_off <= 1'b0;
		else if (latch_pol_ff && (ov_shutdown | ot_shutdown | oc_trip))
			latched_off <= 1'b1;
		else if (restart_ok)
			latched_off <= 1'b0;
	end

	// hiccup below 36V in limit when in restart mode
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			hiccup <= 1'b0;
		else
			hiccup <= (power_limit | current_limit) && !blink_zone && !latch_pol_ff;
	end

	// ----------------------------------------
	// command status byte
	// ----------------------------------------
	logic [7:0] nxt_cs;

	always_comb
	begin
		nxt_cs = cmd_status;
		// clear drops the information bits first, new events win below
		if (do_clear)
		begin
			nxt_cs[`PSA_CS_PEC_ERR] = 1'b0;
			nxt_cs[`PSA_CS_BAD_CMD] = 1'b0;
			nxt_cs[`PSA_CS_ISO_FAIL] = 1'b0;
			nxt_cs[`PSA_CS_RESTART_OK] = 1'b0;
			nxt_cs[`PSA_CS_BAD_DATA] = 1'b0;
		end
		if (pec_bad)
			nxt_cs[`PSA_CS_PEC_ERR] = 1'b1;
		if (bad_cmd)
			nxt_cs[`PSA_CS_BAD_CMD] = 1'b1;
		if (iso_done && !iso_pass)
			nxt_cs[`PSA_CS_ISO_FAIL] = 1'b1;
		if (restart_ok)
			nxt_cs[`PSA_CS_RESTART_OK] = 1'b1;
		// out-of-range data holds the flag against clear
		if (data_out_of_range)
			nxt_cs[`PSA_CS_BAD_DATA] = 1'b1;
		nxt_cs[`PSA_CS_WILL_RESTART] = !latch_pol_ff;
		nxt_cs[`PSA_CS_HIGH_LINE] = high_line;
		nxt_cs[`PSA_CS_ENABLE_HI] = en_hi_ff;
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			cmd_status <= `PSA_BYTE_RST;
		else
			cmd_status <= nxt_cs;
	end

	// alert follows the invalid command flag, released by clear
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			alert_out <= 1'b0;
			alert_oe <= 1'b0;
		end
		else
		begin
			alert_out <= 1'b0;
			alert_oe <= nxt_cs[`PSA_CS_BAD_CMD];
		end
	end

	// ----------------------------------------
	// unit status byte
	// ----------------------------------------
	logic iso_pass_ff;
	logic otr_on_ff;
	psa_pkg::psa_lamp_e lamp_ff;

	// iso pass is sticky until clear; a new result wins over clear
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			iso_pass_ff <= 1'b0;
		else if (iso_done)
			iso_pass_ff <= iso_pass;
		else if (do_clear)
			iso_pass_ff <= 1'b0;
	end

	// unit status layout; internal fault only from its own monitor
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			unit_status <= `PSA_BYTE_RST;
		else
			unit_status <= {1'b0, iso_pass_ff, int_fault, shutdown | latched_off,
				otr_on_ff, ext_fault, lamp_ff != psa_pkg::PSA_LAMP_IDLE, output_on};
	end

	// ----------------------------------------
	// alarm bytes, sticky until a restart
	// ----------------------------------------
	logic [15:0] share_diff;
	logic [7:0]  hw_now;
	logic [7:0]  op_now;

	assign share_diff = (iout_own > iout_share) ? iout_own - iout_share
		: iout_share - iout_own;
	// hardware alarm layout; delivery fault above 10A
	assign hw_now = {fan_fault, no_primary, primary_ot, dcdc_ot, out_below_bus,
		tsense_fail, aux5_fault, share_diff > `PSA_SHARE_DIFF_MAX};
	assign op_now = {power_limit, primary_fail, ot_shutdown, ot_warning, oc_trip,
		ov_shutdown, vout_out_lim, vin_out_lim};

	// restart wipes old alarms; conditions present now are kept
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			hw_alarm <= `PSA_BYTE_RST;
			op_alarm <= `PSA_BYTE_RST;
		end
		else if (restart_ok)
		begin
			hw_alarm <= hw_now;
			op_alarm <= op_now;
		end
		else
		begin
			hw_alarm <= hw_alarm | hw_now;
			op_alarm <= op_alarm | op_now;
		end
	end

	// ----------------------------------------
	// status read snapshot
	// ----------------------------------------
	// all four bytes captured in the same cycle; with analog data
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			rd_done <= 1'b0;
			rd_cmd_status <= `PSA_BYTE_RST;
			rd_unit_status <= `PSA_BYTE_RST;
			rd_hw_alarm <= `PSA_BYTE_RST;
			rd_op_alarm <= `PSA_BYTE_RST;
			rd_vout <= {2{`PSA_BYTE_RST}};
			rd_iout <= `PSA_BYTE_RST;
			rd_temp <= `PSA_BYTE_RST;
		end
		else
		begin
			rd_done <= exec && cmd_code == `PSA_CMD_READ_STATUS;
			if (exec && cmd_code == `PSA_CMD_READ_STATUS)
			begin
				rd_cmd_status <= cmd_status;
				rd_unit_status <= unit_status;
				rd_hw_alarm <= hw_alarm;
				rd_op_alarm <= op_alarm;
				rd_vout <= vout_code;
				rd_iout <= iout_own[7:0];
				rd_temp <= temp_code;
			end
		end
	end

	// ----------------------------------------
	// millisecond tick
	// ----------------------------------------
	// one divider feeds every slow timer so they all share a single enable
	logic [15:0] div_ff;
	logic        ms_tick_ff;

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			div_ff <= 16'h0000;
			ms_tick_ff <= 1'b0;
		end
		else
		begin
			ms_tick_ff <= (div_ff == 16'(MS_TICK_CYC - 1));
			div_ff <= (div_ff == 16'(MS_TICK_CYC - 1)) ? 16'h0000 : div_ff + 16'h0001;
		end
	end

	// ----------------------------------------
	// lamp test
	// ----------------------------------------
	psa_pkg::psa_ms_t lamp_ms_ff;

	// 7 s lit, 2 s dark, repeated until the stop command
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			lamp_ff <= psa_pkg::PSA_LAMP_IDLE;
			lamp_ms_ff <= 13'h0000;
		end
		else if (exec && cmd_code == `PSA_CMD_LAMP_STOP)
		begin
			lamp_ff <= psa_pkg::PSA_LAMP_IDLE;
			lamp_ms_ff <= 13'h0000;
		end
		else if (exec && cmd_code == `PSA_CMD_LAMP_START)
		begin
			lamp_ff <= psa_pkg::PSA_LAMP_LIT;
			lamp_ms_ff <= 13'h0000;
		end
		else if (ms_tick_ff)
		begin
			unique case (lamp_ff)
				psa_pkg::PSA_LAMP_IDLE:
					lamp_ms_ff <= 13'h0000;
				psa_pkg::PSA_LAMP_LIT:
					if (lamp_ms_ff == 13'(`PSA_LAMP_ON_MS - 1))
					begin
						lamp_ff <= psa_pkg::PSA_LAMP_DARK;
						lamp_ms_ff <= 13'h0000;
					end
					else
						lamp_ms_ff <= lamp_ms_ff + 13'h0001;
				psa_pkg::PSA_LAMP_DARK:
					if (lamp_ms_ff == 13'(`PSA_LAMP_OFF_MS - 1))
					begin
						lamp_ff <= psa_pkg::PSA_LAMP_LIT;
						lamp_ms_ff <= 13'h0000;
					end
					else
						lamp_ms_ff <= lamp_ms_ff + 13'h0001;
			endcase
		end
	end

	// ----------------------------------------
	// ok-to-remove flash and output blink
	// ----------------------------------------
	logic [9:0] flash_ms_ff;
	logic       flash_ph_ff;

	// half-second phase, restarted by a flash command while the LED is off, shared by service flash and limit blink
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			flash_ms_ff <= 10'h000;
			flash_ph_ff <= 1'b0;
		end
		else if (exec && cmd_code == `PSA_CMD_OTR_FLASH && !otr_on_ff)
		begin
			flash_ms_ff <= 10'h000;
			flash_ph_ff <= 1'b1;
		end
		else if (ms_tick_ff)
		begin
			if (flash_ms_ff == 10'(`PSA_FLASH_HALF_MS - 1))
			begin
				flash_ms_ff <= 10'h000;
				flash_ph_ff <= !flash_ph_ff;
			end
			else
				flash_ms_ff <= flash_ms_ff + 10'h001;
		end
	end

	// start flashing; stop and go dark
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			otr_on_ff <= 1'b0;
		else if (exec && cmd_code == `PSA_CMD_OTR_FLASH)
			otr_on_ff <= 1'b1;
		else if (exec && cmd_code == `PSA_CMD_OTR_DARK)
			otr_on_ff <= 1'b0;
	end

	// led0 output, led1 ok-to-remove, led2 fault, led3 input ok
	logic out_led;

	// latched off is dark, blink above 36V in limit, else follow output
	assign out_led = latched_off ? 1'b0 : (blink_zone ? flash_ph_ff : output_on);

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			front_led <= 4'h0;
		else if (lamp_ff == psa_pkg::PSA_LAMP_LIT)
			front_led <= 4'hF;
		else if (lamp_ff == psa_pkg::PSA_LAMP_DARK)
			front_led <= 4'h0;
		else
			front_led <= {!primary_fail, int_fault | ext_fault,
				otr_on_ff & flash_ph_ff, out_led};
	end

	// ----------------------------------------
	// eeprom write permission
	// ----------------------------------------
	logic [3:0] unl_ms_ff;
	logic       unl_busy_ff;

	// permission granted after the 10 ms completion time
	// lock takes effect at once and cancels a pending unlock
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			eeprom_wr_ok <= 1'b0;
			unl_busy_ff <= 1'b0;
			unl_ms_ff <= 4'h0;
		end
		else if (exec && cmd_code == `PSA_CMD_WR_LOCK)
		begin
			eeprom_wr_ok <= 1'b0;
			unl_busy_ff <= 1'b0;
			unl_ms_ff <= 4'h0;
		end
		else if (exec && cmd_code == `PSA_CMD_WR_UNLOCK && !eeprom_wr_ok)
		begin
			unl_busy_ff <= 1'b1;
			unl_ms_ff <= 4'h0;
		end
		else if (unl_busy_ff && ms_tick_ff)
		begin
			if (unl_ms_ff == 4'(`PSA_UNLOCK_MS - 1))
			begin
				eeprom_wr_ok <= 1'b1;
				unl_busy_ff <= 1'b0;
			end
			else
				unl_ms_ff <= unl_ms_ff + 4'h1;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	chk_pec_sets_flag: assert property (pec_bad |=> cmd_status[`PSA_CS_PEC_ERR])
		else $error("pec error not flagged");
	chk_bad_cmd_alert: assert property (bad_cmd |=> alert_oe && !alert_out)
		else $error("unsupported command did not raise alert");
	chk_clear_info: assert property (do_clear && !restart_ok && !iso_done
		|=> !cmd_status[`PSA_CS_RESTART_OK] ##1 !unit_status[`PSA_US_ISO_PASS])
		else $error("clear left information bits set");
	chk_bad_data_hold: assert property (data_out_of_range |=>
		cmd_status[`PSA_CS_BAD_DATA])
		else $error("out of range flag dropped");
	chk_will_restart: assert property (exec && cmd_code == `PSA_CMD_LATCH_POLICY
		|=> ##1 !cmd_status[`PSA_CS_WILL_RESTART])
		else $error("restart bit ignores latch policy");
	chk_iso_fail_info: assert property (iso_done && !iso_pass && !int_fault
		|=> cmd_status[`PSA_CS_ISO_FAIL] && !unit_status[`PSA_US_INT_FAULT])
		else $error("isolation failure handled wrongly");
	chk_restart_clears: assert property (restart_ok && hw_now == 8'h00
		&& op_now == 8'h00 |=> hw_alarm == 8'h00 && op_alarm == 8'h00
		&& cmd_status[`PSA_CS_RESTART_OK])
		else $error("restart did not clear alarms");
	chk_enable_mirror: assert property ($rose(en_s3_ff) && en_s2_ff
		|=> ##1 cmd_status[`PSA_CS_ENABLE_HI])
		else $error("enable pin not mirrored");
	chk_delivery_fault: assert property (share_diff > `PSA_SHARE_DIFF_MAX
		|=> hw_alarm[0])
		else $error("delivery fault missed");
	chk_latch_holds: assert property (latched_off && !restart_ok |=> latched_off)
		else $error("latch released without restart");
	chk_lock_now: assert property (exec && cmd_code == `PSA_CMD_WR_LOCK
		|=> !eeprom_wr_ok [*3])
		else $error("lock did not remove permission");
	chk_lamp_stop: assert property (exec && cmd_code == `PSA_CMD_LAMP_STOP
		|=> lamp_ff == psa_pkg::PSA_LAMP_IDLE ##1 !unit_status[`PSA_US_LAMP_TEST])
		else $error("lamp test did not stop");
	chk_read_snap: assert property (rd_done |-> rd_cmd_status == $past(cmd_status)
		&& rd_op_alarm == $past(op_alarm))
		else $error("status read snapshot mismatch");

	cov_status_read: cover property (exec && cmd_code == `PSA_CMD_READ_STATUS ##1 rd_done);
	cov_lamp_dark: cover property (lamp_ff == psa_pkg::PSA_LAMP_DARK);
	cov_unlock_done: cover property ($rose(eeprom_wr_ok));
	cov_latched: cover property ($rose(latched_off));

endmodule

`default_nettype wire

/* File: pkg/psa_cfg.svh */
// psa_cfg.svh: offsets, field positions, command codes and timing counts of the
// status and alarm block; included by the design file only.
`ifndef PSA_CFG_SVH
`define PSA_CFG_SVH

// ----------------------------------------
// command codes
// ----------------------------------------
`define PSA_CMD_OPERATION     8'h01
`define PSA_CMD_CLEAR         8'h03
`define PSA_CMD_VOUT_SET      8'h21
`define PSA_CMD_OV_LIMIT      8'h40
`define PSA_CMD_READ_STATUS   8'hD0
`define PSA_CMD_LAMP_START    8'hD2
`define PSA_CMD_LAMP_STOP     8'hD3
`define PSA_CMD_OTR_FLASH     8'hD4
`define PSA_CMD_OTR_DARK      8'hD5
`define PSA_CMD_WR_UNLOCK     8'hD6
`define PSA_CMD_WR_LOCK       8'hD7
`define PSA_CMD_LATCH_POLICY  8'hD8
`define PSA_CMD_AUTO_RESTART  8'hD9
`define PSA_CMD_ISO_TEST      8'hDA
`define PSA_CMD_RD_INPUT      8'hDC
`define PSA_CMD_RD_FW         8'hDD
`define PSA_CMD_RD_TIMER      8'hDE
`define PSA_CMD_FAN_SET       8'hDF
`define PSA_CMD_FAN_NORMAL    8'hE0
`define PSA_CMD_RD_FAN        8'hE1
`define PSA_CMD_STRETCH       8'hF2

// ----------------------------------------
// command status byte fields
// ----------------------------------------
`define PSA_CS_PEC_ERR        7
`define PSA_CS_WILL_RESTART   6
`define PSA_CS_BAD_CMD        5
`define PSA_CS_HIGH_LINE      4
`define PSA_CS_ISO_FAIL       3
`define PSA_CS_RESTART_OK     2
`define PSA_CS_BAD_DATA       1
`define PSA_CS_ENABLE_HI      0

// ----------------------------------------
// unit status byte fields
// ----------------------------------------
`define PSA_US_ISO_PASS       6
`define PSA_US_INT_FAULT      5
`define PSA_US_SHUTDOWN       4
`define PSA_US_OTR_LED        3
`define PSA_US_EXT_FAULT      2
`define PSA_US_LAMP_TEST      1
`define PSA_US_OUTPUT_ON      0

// ----------------------------------------
// reset values
// ----------------------------------------
`define PSA_BYTE_RST          8'h00

// ----------------------------------------
// analog thresholds (vout code is 400 per volt, current code 5 per amp)
// ----------------------------------------
`define PSA_VOUT_OC_TRIP      16'h3CF0
`define PSA_VOUT_BLINK_MIN    16'h3840
`define PSA_SHARE_DIFF_MAX    16'h0032

// ----------------------------------------
// timing
// ----------------------------------------
`define PSA_CLK_HZ            50000000
`define PSA_MS_PER_S          1000
`define PSA_MS_TICK_CYC       (`PSA_CLK_HZ / `PSA_MS_PER_S)
`define PSA_LAMP_ON_S         7
`define PSA_LAMP_OFF_S        2
`define PSA_FLASH_HALF_MS     500
`define PSA_UNLOCK_MS         10
`define PSA_LAMP_ON_MS        (`PSA_LAMP_ON_S * `PSA_MS_PER_S)
`define PSA_LAMP_OFF_MS       (`PSA_LAMP_OFF_S * `PSA_MS_PER_S)

`endif

/* File: pkg/psa_pkg.sv */
// psa_pkg: types shared by the status and alarm block.
// assumes psa_cfg.svh is on the include path.
`default_nettype none

package psa_pkg;
	typedef logic [7:0]  psa_byte_t;
	typedef logic [12:0] psa_ms_t;
	typedef enum logic [1:0] {
		PSA_LAMP_IDLE,
		PSA_LAMP_LIT,
		PSA_LAMP_DARK
	} psa_lamp_e;
endpackage

`default_nettype wire

/* File: test/psa_host_model.sv */
// psa_host_model: host side that hands framed commands to the status block.
// assumes one command at a time, pec already judged by the framing logic.
`default_nettype none
module psa_host_model (
	input  wire logic       mclk,
	output logic            cmd_valid,
	output logic [7:0]      cmd_code,
	output logic            cmd_pec_ok
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		cmd_valid = 1'b0;
		cmd_code = 8'h00;
		cmd_pec_ok = 1'b1;
	end
	// pec verdict rides with code
	// idle lines show the inverse so stale values never look valid
	task automatic send(input logic [7:0] code, input logic pec);
		@(posedge mclk);
		cmd_valid <= 1'b1;
		cmd_code <= code;
		cmd_pec_ok <= pec;
		@(posedge mclk);
		cmd_valid <= 1'b0;
		cmd_code <= ~code;
		cmd_pec_ok <= ~pec;
	endtask
endmodule
`default_nettype wire

/* File: test/psu_status_alarm_commands_test.sv */
// psu_status_alarm_commands_test: drives commands and monitor levels, checks bytes and leds.
// assumes the ms tick is cut to 4 cycles so timers stay short.
`default_nettype none
module psu_status_alarm_commands_test;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int LIMIT = 40000;
	logic mclk = 1'b0, sys_rst = 1'b1, enable_pin = 1'b0, high_line = 1'b1;
	logic data_out_of_range = 1'b0, iso_done = 1'b0, iso_pass = 1'b0, restart_ok = 1'b0;
	logic [3:0] us_in = 4'h0;
	logic [7:0] hw_in = 8'h00, op_in = 8'h00;
	logic [15:0] vout = 16'h4ED4, iout_own = 16'h0064;
	logic cmd_valid, cmd_pec_ok, rd_done, alert_out, alert_oe, eeprom_wr_ok, latched_off, hiccup;
	logic [7:0] rd_unit_status, rd_hw_alarm, rd_iout, rd_temp;
	logic [7:0] cmd_code, cmd_status, unit_status, hw_alarm, op_alarm, rd_cmd_status, rd_op_alarm;
	logic [15:0] rd_vout;
	logic [3:0] front_led;
	int failures = 0, check_count = 0, cycles = 0;
	psa_host_model i_host (.mclk, .cmd_valid, .cmd_code, .cmd_pec_ok);
	psa_status_alarm #(.MS_TICK_CYC(4)) i_dut (
		.mclk, .sys_rst, .cmd_valid, .cmd_code, .cmd_pec_ok, .data_out_of_range, .enable_pin,
		.high_line, .iso_done, .iso_pass, .restart_ok, .int_fault(us_in[3]), .ext_fault(us_in[2]),
		.shutdown(us_in[1]), .output_on(us_in[0]), .fan_fault(hw_in[7]), .no_primary(hw_in[6]),
		.primary_ot(hw_in[5]), .dcdc_ot(hw_in[4]), .out_below_bus(hw_in[3]),
		.tsense_fail(hw_in[2]), .aux5_fault(hw_in[1]), .power_limit(op_in[7]),
		.primary_fail(op_in[6]), .ot_shutdown(op_in[5]), .ot_warning(op_in[4]),
		.current_limit(op_in[3]), .ov_shutdown(op_in[2]), .vout_out_lim(op_in[1]),
		.vin_out_lim(op_in[0]), .vout_code(vout), .iout_own, .iout_share(16'h0064),
		.temp_code(8'h2A), .cmd_status, .unit_status, .hw_alarm, .op_alarm, .rd_done,
		.rd_cmd_status, .rd_unit_status, .rd_hw_alarm, .rd_op_alarm, .rd_vout, .rd_iout,
		.rd_temp, .alert_out, .alert_oe, .front_led, .eeprom_wr_ok, .latched_off, .hiccup);
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			failures++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic cmd(input logic [7:0] code, input logic pec = 1'b1);
		i_host.send(code, pec);
		settle(2);
	endtask
	initial
	begin
		forever #10 mclk = ~mclk;
	end
	// a hang ends the run through the same report
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == LIMIT)
		begin
			failures++;
			conclude();
		end
	end
	initial
	begin
		repeat (12) @(posedge mclk);
		sys_rst <= 1'b0;
		enable_pin <= 1'b1;
		settle(6);
		check("cmd_status", cmd_status, 8'h51);
		cmd(8'h55);
		check("cmd_status", cmd_status, 8'h71);
		check("alert_oe", alert_oe, 1'b1);
		check("alert_out", alert_out, 1'b0);
		cmd(8'hD2, 1'b0);
		check("cmd_status", cmd_status, 8'hF1);
		check("unit_status", unit_status, 8'h00);
		data_out_of_range <= 1'b1;
		cmd(8'h03);
		check("cmd_status", cmd_status, 8'h53);
		check("alert_oe", alert_oe, 1'b0);
		data_out_of_range <= 1'b0;
		cmd(8'h03);
		check("cmd_status", cmd_status, 8'h51);
		iso_done <= 1'b1;
		@(posedge mclk);
		iso_done <= 1'b0;
		settle(2);
		check("cmd_status", cmd_status, 8'h59);
		check("unit_status", unit_status, 8'h00);
		iso_done <= 1'b1;
		iso_pass <= 1'b1;
		@(posedge mclk);
		iso_done <= 1'b0;
		settle(2);
		check("unit_status", unit_status, 8'h40);
		cmd(8'h03);
		check("cmd_status", cmd_status, 8'h51);
		check("unit_status", unit_status, 8'h00);
		us_in <= 4'hD;
		hw_in <= 8'hFE;
		op_in <= 8'hF7;
		settle(3);
		check("unit_status", unit_status, 8'h25);
		check("hw_alarm", hw_alarm, 8'hFE);
		check("op_alarm", op_alarm, 8'hF7);
		us_in <= 4'h0;
		hw_in <= 8'h00;
		op_in <= 8'h08;
		vout <= 16'h3CF0;
		iout_own <= 16'h0096;
		settle(3);
		check("hw_alarm", hw_alarm, 8'hFE);
		check("op_alarm", op_alarm, 8'hF7);
		vout <= 16'h3CEF;
		iout_own <= 16'h0097;
		settle(3);
		check("hw_alarm", hw_alarm, 8'hFF);
		check("op_alarm", op_alarm, 8'hFF);
		vout <= 16'h3840;
		settle(3);
		check("hiccup", hiccup, 1'b1);
		i_host.send(8'hD0, 1'b1);
		#1;
		check("rd_done", rd_done, 1'b1);
		check("rd_op_alarm", rd_op_alarm, 8'hFF);
		check("rd_vout", rd_vout, 16'h3840);
		check("rd_cmd_status", rd_cmd_status, 8'h51);
		check("rd_hw_alarm", rd_hw_alarm, 8'hFF);
		check("rd_unit_status", rd_unit_status, 8'h00);
		check("rd_iout", rd_iout, 8'h97);
		check("rd_temp", rd_temp, 8'h2A);
		cmd(8'hD8);
		check("cmd_status", cmd_status, 8'h11);
		check("hiccup", hiccup, 1'b0);
		op_in <= 8'h04;
		vout <= 16'h4ED4;
		iout_own <= 16'h0064;
		settle(3);
		op_in <= 8'h00;
		settle(3);
		check("latched_off", latched_off, 1'b1);
		check("unit_status", unit_status, 8'h10);
		check("output led", front_led[0], 1'b0);
		restart_ok <= 1'b1;
		@(posedge mclk);
		restart_ok <= 1'b0;
		settle(2);
		check("hw_alarm", hw_alarm, 8'h00);
		check("op_alarm", op_alarm, 8'h00);
		check("cmd_status", cmd_status, 8'h15);
		check("latched_off", latched_off, 1'b0);
		cmd(8'hD9);
		check("cmd_status", cmd_status, 8'h55);
		cmd(8'h03);
		check("cmd_status", cmd_status, 8'h51);
		cmd(8'hD2);
		check("front_led", front_led, 4'hF);
		check("unit_status", unit_status, 8'h02);
		settle(28010);
		check("front_led", front_led, 4'h0);
		check("unit_status", unit_status, 8'h02);
		cmd(8'hD3);
		check("unit_status", unit_status, 8'h00);
		cmd(8'hD4);
		check("unit_status", unit_status, 8'h08);
		check("flash led", front_led[1], 1'b1);
		settle(2010);
		check("flash led", front_led[1], 1'b0);
		cmd(8'hD5);
		check("unit_status", unit_status, 8'h00);
		check("flash led", front_led[1], 1'b0);
		cmd(8'hD6);
		check("eeprom_wr_ok", eeprom_wr_ok, 1'b0);
		settle(50);
		check("eeprom_wr_ok", eeprom_wr_ok, 1'b1);
		cmd(8'hD7);
		check("eeprom_wr_ok", eeprom_wr_ok, 1'b0);
		cmd(8'hD8);
		sys_rst <= 1'b1;
		settle(2);
		sys_rst <= 1'b0;
		settle(6);
		check("cmd_status", cmd_status, 8'h51);
		conclude();
	end
endmodule
`default_nettype wire
